// ==== common/adcts_pkg.sv ====
// constants and register layout for the converter timing and input select block
package adcts_pkg;
  // register byte addresses on the apb slave
  localparam logic [11:0] ADCTS_OFF_TIMING = 12'h000;
  localparam logic [11:0] ADCTS_OFF_CHSEL  = 12'h004;
  localparam logic [11:0] ADCTS_OFF_SCAN   = 12'h008;
  localparam logic [11:0] ADCTS_OFF_MODE   = 12'h00C;
  localparam logic [11:0] ADCTS_OFF_STATUS = 12'h010;
  // timing control fields
  localparam int ADCTS_SRC_BIT   = 15;
  localparam int ADCTS_AUTO_SAMPLE_PERIODS_LSB  = 8;
  localparam int ADCTS_AUTO_SAMPLE_PERIODS_W    = 5;
  localparam int ADCTS_DIV_LSB   = 0;
  localparam int ADCTS_DIV_W     = 8;
  localparam logic [15:0] ADCTS_TIMING_MASK = 16'h9FFF;
  // mode register fields
  localparam int ADCTS_MODE_12B_BIT = 0;
  localparam int ADCTS_MODE_OA_LSB  = 1;
  localparam int ADCTS_MODE_CMP_LSB = 4;
  localparam int ADCTS_NUM_OA       = 3;
  localparam int ADCTS_NUM_CMP      = 4;
  // number of analog inputs physically present
  localparam int ADCTS_NUM_AN       = 9;
  // reset values
  localparam logic [15:0] ADCTS_RST_TIMING = 16'h0000;
  localparam logic [15:0] ADCTS_RST_SCAN   = 16'h0000;
  // analog source codes driven to the multiplexer
  localparam logic [4:0] ADCTS_SRC_AN0  = 5'h00;
  localparam logic [4:0] ADCTS_SRC_OA1  = 5'h11;
  localparam logic [4:0] ADCTS_SRC_OA2  = 5'h12;
  localparam logic [4:0] ADCTS_SRC_OA3  = 5'h13;
  localparam logic [4:0] ADCTS_SRC_NEGATIVE_REFERENCE_LEVEL = 5'h1F;
  localparam logic [4:0] ADCTS_SRC_AN1  = 5'h01;
  localparam logic [4:0] ADCTS_SRC_AN2  = 5'h02;
  localparam logic [4:0] ADCTS_SRC_AN3  = 5'h03;
  localparam logic [4:0] ADCTS_SRC_AN6  = 5'h06;
  localparam logic [31:0] ADCTS_ERR_DATA = 32'h00000000;
endpackage : adcts_pkg

// ==== src/adcts_clkgen.sv ====
// converter clock period generator and auto-sample counter
`timescale 1ns/1ns
module adcts_clkgen
  import adcts_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    use_rc,
  input  wire logic                    rc_tick,
  input  wire logic [ADCTS_DIV_W-1:0]  divider,
  input  wire logic [ADCTS_AUTO_SAMPLE_PERIODS_W-1:0] auto_sample_periods,
  input  wire logic                    sample_start,
  output logic                         tad_tick,
  output logic                         sampling,
  output logic                         sample_done
);
  logic [ADCTS_DIV_W-1:0]  div_cnt_r;
  logic [ADCTS_AUTO_SAMPLE_PERIODS_W-1:0] smp_cnt_r;
  logic                    sys_tick;

  assign sys_tick = (div_cnt_r == divider);

  // divide by divider + 1; divider is ignored when the rc source runs
  always_ff @(posedge clk_sys) begin
    if (srst || use_rc || sys_tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tad_tick <= 1'b0;
    end else begin
      tad_tick <= use_rc ? rc_tick : sys_tick;
    end
  end

  // sample window counts auto_sample_periods converter periods; zero ends at once
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sampling    <= 1'b0;
      smp_cnt_r   <= '0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= 1'b0;
      if (sample_start && !sampling) begin
        if (auto_sample_periods == 5'h00) begin
          sample_done <= 1'b1;
        end else begin
          sampling  <= 1'b1;
          smp_cnt_r <= auto_sample_periods;
        end
      end else if (sampling && tad_tick) begin
        if (smp_cnt_r == 5'h01) begin
          sampling    <= 1'b0;
          sample_done <= 1'b1;
        end
        smp_cnt_r <= smp_cnt_r - 5'h01;
      end
    end
  end
endmodule : adcts_clkgen

// ==== src/adcts_mux.sv ====
// positive input steering for sample channels 1 to 3
`timescale 1ns/1ns
module adcts_mux
  import adcts_pkg::*;
(
  input  wire logic                     ch_sel,
  input  wire logic [ADCTS_NUM_OA-1:0]  oa_en,
  input  wire logic [ADCTS_NUM_CMP-1:0] cmp_en,
  output logic      [4:0]               ch1_src,
  output logic      [4:0]               ch2_src,
  output logic      [4:0]               ch3_src,
  output logic      [7:0]               an_repurposed
);
  function automatic logic [4:0] pick(input logic en, input logic [4:0] oa,
                                      input logic [4:0] an);
    pick = en ? oa : an;
  endfunction : pick

  always_comb begin
    if (ch_sel) begin
      ch1_src = pick(oa_en[0], ADCTS_SRC_OA1, ADCTS_SRC_AN3);
      ch2_src = pick(oa_en[1], ADCTS_SRC_OA2, ADCTS_SRC_AN0);
      ch3_src = pick(oa_en[2], ADCTS_SRC_OA3, ADCTS_SRC_AN6);
    end else begin
      ch1_src = pick(oa_en[1], ADCTS_SRC_OA2, ADCTS_SRC_AN0);
      ch2_src = ADCTS_SRC_AN1;
      ch3_src = ADCTS_SRC_AN2;
    end
  end

  // pins used by op amp or comparator inputs are taken from general use
  always_comb begin
    an_repurposed = 8'h00;
    an_repurposed[0] = oa_en[1] | cmp_en[1];
    an_repurposed[1] = oa_en[1] | cmp_en[1];
    an_repurposed[2] = oa_en[0] | cmp_en[0];
    an_repurposed[3] = oa_en[0] | cmp_en[0];
    an_repurposed[4] = oa_en[0] | cmp_en[0];
    an_repurposed[5] = oa_en[2] | cmp_en[2];
    an_repurposed[6] = oa_en[2] | cmp_en[2];
    an_repurposed[7] = cmp_en[3];
  end
endmodule : adcts_mux

// ==== src/adcts_top.sv ====
// apb register file and configuration outputs of the converter controller
`timescale 1ns/1ns
// How it works
// - source bit one picks internal rc clock, zero the system-derived clock
// - channel select bit steers channels 1-3 between two input sets
// - in 12-bit single-channel mode the channel select bit reads zero
// - op amp output used when its mode bit is one, else the pin; op amps 1 and 3 only while channel select is one
// - inputs 0-6 repurposed when their comparator or op amp is enabled; input 7 never is, as comparator 4 has no enable bit
// - unimplemented bits, including timing bits 14 and 13, read zero
// - each scan mask bit includes or skips its analog input
// - masked slot without a physical input converts negative reference
module adcts_top
  import adcts_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rc_tick,
  input  wire logic        sample_start,
  input  wire logic [3:0]  scan_slot,
  output logic             conv_clock_source_sel,
  output logic             tad_tick,
  output logic             sampling,
  output logic             sample_done,
  output logic      [4:0]  ch1_src,
  output logic      [4:0]  ch2_src,
  output logic      [4:0]  ch3_src,
  output logic      [7:0]  an_repurposed,
  output logic             slot_scanned,
  output logic      [4:0]  slot_src
);
  logic [15:0] timing_r;
  logic [15:0] scan_r;
  logic        ch_sel_r;
  logic [7:0]  mode_r;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] rd_nxt;
  logic        ch_sel_eff;
  logic        use_rc;
  logic        tad_w;
  logic        smp_w;
  logic        done_w;
  logic [4:0]  c1_w;
  logic [4:0]  c2_w;
  logic [4:0]  c3_w;
  logic [7:0]  rep_w;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit = (paddr == ADCTS_OFF_TIMING) || (paddr == ADCTS_OFF_CHSEL) ||
               (paddr == ADCTS_OFF_SCAN) || (paddr == ADCTS_OFF_MODE) ||
               (paddr == ADCTS_OFF_STATUS);
  assign use_rc = timing_r[ADCTS_SRC_BIT];
  // channel select has no storage effect in 12-bit mode
  assign ch_sel_eff = ch_sel_r && !mode_r[ADCTS_MODE_12B_BIT];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      timing_r <= ADCTS_RST_TIMING;
    end else if (wr_en && paddr == ADCTS_OFF_TIMING) begin
      timing_r <= merge16(timing_r, pwdata, pstrb) & ADCTS_TIMING_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scan_r <= ADCTS_RST_SCAN;
    end else if (wr_en && paddr == ADCTS_OFF_SCAN) begin
      scan_r <= merge16(scan_r, pwdata, pstrb);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ch_sel_r <= 1'b0;
    end else if (wr_en && paddr == ADCTS_OFF_CHSEL && pstrb[0]) begin
      // write ignored while the bit is unimplemented
      if (!mode_r[ADCTS_MODE_12B_BIT]) begin
        ch_sel_r <= pwdata[0];
      end
    end else if (mode_r[ADCTS_MODE_12B_BIT]) begin
      ch_sel_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r <= 8'h00;
    end else if (wr_en && paddr == ADCTS_OFF_MODE && pstrb[0]) begin
      mode_r <= {1'b0, pwdata[6:0]};
    end
  end

  always_comb begin
    rd_nxt = ADCTS_ERR_DATA;
    if (paddr == ADCTS_OFF_TIMING) begin
      rd_nxt = {16'h0000, timing_r & ADCTS_TIMING_MASK};
    end else if (paddr == ADCTS_OFF_CHSEL) begin
      rd_nxt = {31'h00000000, ch_sel_eff};
    end else if (paddr == ADCTS_OFF_SCAN) begin
      rd_nxt = {16'h0000, scan_r};
    end else if (paddr == ADCTS_OFF_MODE) begin
      rd_nxt = {24'h000000, mode_r};
    end else if (paddr == ADCTS_OFF_STATUS) begin
      rd_nxt = {24'h000000, 5'h00, done_w, smp_w, use_rc};
    end
  end

  // no wait state: data latched in setup, answer in first access cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en) begin
        prdata <= rd_nxt;
      end
    end
  end

  adcts_clkgen u_clkgen (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .use_rc       (use_rc),
    .rc_tick      (rc_tick),
    .divider      (timing_r[ADCTS_DIV_LSB +: ADCTS_DIV_W]),
    .auto_sample_periods         (timing_r[ADCTS_AUTO_SAMPLE_PERIODS_LSB +: ADCTS_AUTO_SAMPLE_PERIODS_W]),
    .sample_start (sample_start),
    .tad_tick     (tad_w),
    .sampling     (smp_w),
    .sample_done  (done_w)
  );

  adcts_mux u_mux (
    .ch_sel        (ch_sel_eff),
    .oa_en         (mode_r[ADCTS_MODE_OA_LSB +: ADCTS_NUM_OA]),
    .cmp_en        (mode_r[ADCTS_MODE_CMP_LSB +: 3] == 3'h0 ? 4'h0 :
                    {1'b0, mode_r[ADCTS_MODE_CMP_LSB +: 3]}),
    .ch1_src       (c1_w),
    .ch2_src       (c2_w),
    .ch3_src       (c3_w),
    .an_repurposed (rep_w)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_clock_source_sel <= 1'b0;
      tad_tick              <= 1'b0;
      sampling              <= 1'b0;
      sample_done           <= 1'b0;
      ch1_src               <= 5'h00;
      ch2_src               <= 5'h00;
      ch3_src               <= 5'h00;
      an_repurposed         <= 8'h00;
    end else begin
      conv_clock_source_sel <= use_rc;
      tad_tick              <= tad_w;
      sampling              <= smp_w;
      sample_done           <= done_w;
      ch1_src               <= c1_w;
      ch2_src               <= c2_w;
      ch3_src               <= c3_w;
      an_repurposed         <= rep_w;
    end
  end

  // scan slot lookup for the sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slot_scanned <= 1'b0;
      slot_src     <= 5'h00;
    end else begin
      slot_scanned <= scan_r[scan_slot];
      if (32'(scan_slot) >= ADCTS_NUM_AN) begin
        slot_src <= ADCTS_SRC_NEGATIVE_REFERENCE_LEVEL;
      end else begin
        slot_src <= {1'b0, scan_slot};
      end
    end
  end
endmodule : adcts_top

// ==== testbench/adcts_monitor.sv ====
// port checker for the converter timing and input select block
`timescale 1ns/1ns
module adcts_monitor
  import adcts_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        rc_tick,
  input wire logic [3:0]  scan_slot,
  input wire logic        conv_clock_source_sel,
  input wire logic        tad_tick,
  input wire logic        sampling,
  input wire logic        sample_done,
  input wire logic [4:0]  ch2_src,
  input wire logic        slot_scanned,
  input wire logic [4:0]  slot_src
);
  logic [15:0] tim_r, scan_r, m;
  logic        mode12_r, chsel_r, wr, rd;
  logic [2:0]  oa_r;
  logic [8:0]  cnt_r, quiet_r;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign m  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // shadow of the registers, so output checks need no peeking inside
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tim_r    <= 16'h0000;
      scan_r   <= 16'h0000;
      mode12_r <= 1'b0;
      oa_r     <= 3'h0;
      chsel_r  <= 1'b0;
    end else if (wr) begin
      if (paddr == ADCTS_OFF_TIMING) tim_r <= (tim_r & ~m) | (pwdata[15:0] & m);
      if (paddr == ADCTS_OFF_SCAN) scan_r <= (scan_r & ~m) | (pwdata[15:0] & m);
      if (paddr == ADCTS_OFF_MODE && pstrb[0]) begin
        mode12_r <= pwdata[0];
        oa_r     <= pwdata[3:1];
        if (pwdata[0]) chsel_r <= 1'b0;
      end
      if (paddr == ADCTS_OFF_CHSEL && pstrb[0] && !mode12_r) chsel_r <= pwdata[0];
    end
  end
  // settle time since last write; the divider may need a full old period to drain
  always_ff @(posedge clk_sys) begin
    quiet_r <= (srst || wr) ? 9'h000 : quiet_r + {8'h00, quiet_r != 9'h1FF};
    cnt_r   <= tad_tick ? 9'h000 : cnt_r + {8'h00, cnt_r != 9'h1FF};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_src_follows: assert property (wr && paddr == ADCTS_OFF_TIMING && pstrb[1] |-> ##2
    conv_clock_source_sel == $past(pwdata[15], 2)) else $error("clock source bit not applied");
  a_div_period: assert property (tad_tick && !conv_clock_source_sel && quiet_r > 300 |->
    cnt_r == {1'b0, tim_r[7:0]}) else $error("converter period not divider plus one");
  a_rc_path: assert property (conv_clock_source_sel && quiet_r > 4 |->
    tad_tick == $past(rc_tick, 2)) else $error("rc tick not passed through");
  a_timing_read: assert property (rd && paddr == ADCTS_OFF_TIMING |->
    prdata == {16'h0000, tim_r & ADCTS_TIMING_MASK}) else $error("timing readback wrong");
  a_scan_read: assert property (rd && paddr == ADCTS_OFF_SCAN |->
    prdata == {16'h0000, scan_r}) else $error("scan mask readback wrong");
  a_chsel_read: assert property (rd && paddr == ADCTS_OFF_CHSEL |->
    prdata == {31'h00000000, chsel_r}) else $error("channel select readback wrong");
  a_ch2_steer: assert property (quiet_r > 4 |-> ch2_src == (chsel_r ?
    (oa_r[1] ? ADCTS_SRC_OA2 : ADCTS_SRC_AN0) : ADCTS_SRC_AN1)) else $error("ch2 source wrong");
  a_slot_vref: assert property (!$past(srst) && $past(scan_slot) >= 4'h9 |->
    slot_src == ADCTS_SRC_NEGATIVE_REFERENCE_LEVEL) else $error("missing input not negative reference");
  a_slot_mask: assert property (quiet_r > 2 |->
    slot_scanned == scan_r[$past(scan_slot)]) else $error("slot scan flag wrong");
  a_reset_zero: assert property (disable iff (1'b0) srst |=>
    !conv_clock_source_sel && !sampling) else $error("outputs not cleared by reset");
  c_done: cover property (sample_done);
  c_chsel_12b: cover property (rd && paddr == ADCTS_OFF_CHSEL && mode12_r);
  c_div: cover property (tad_tick && !conv_clock_source_sel && quiet_r > 300);
endmodule : adcts_monitor
bind adcts_top adcts_monitor i_mon (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .rc_tick, .scan_slot, .conv_clock_source_sel,
  .tad_tick, .sampling, .sample_done, .ch2_src, .slot_scanned, .slot_src);

// ==== testbench/adcts_conv_model.sv ====
// analog side stand-in: free rc oscillator and sample window tick counter
`timescale 1ns/1ns
module adcts_conv_model
  import adcts_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       clr,
  input  wire logic       tad_tick,
  input  wire logic       sampling,
  output logic            rc_tick,
  output logic      [7:0] ticks
);
  logic [1:0] div_r;
  // rc runs at a quarter rate, unrelated to any divider setting
  always_ff @(posedge clk_sys) begin
    div_r   <= srst ? 2'h0 : div_r + 2'h1;
    rc_tick <= !srst && div_r == 2'h3;
  end
  // converter periods seen inside the sample window
  always_ff @(posedge clk_sys) begin
    if (srst || clr) begin
      ticks <= 8'h00;
    end else if (tad_tick && sampling) begin
      ticks <= ticks + 8'h01;
    end
  end
endmodule : adcts_conv_model

// ==== testbench/adcts_top_bench.sv ====
// self-checking bench for the converter timing and input select block
`timescale 1ns/1ns
module adcts_top_bench
  import adcts_pkg::*;
;
  logic        clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sample_start = 1'b0, clr = 1'b0, slv, rc_tick, pready, pslverr, tad_tick;
  logic        conv_clock_source_sel, sampling, sample_done, slot_scanned;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0]  pstrb = 4'h0, scan_slot = 4'h0;
  logic [4:0]  ch1_src, ch2_src, ch3_src, slot_src;
  logic [7:0]  an_repurposed, ticks;
  logic [7:0]  dv[3] = '{8'h00, 8'h03, 8'hFF};
  logic [4:0]  sv[4] = '{5'h00, 5'h01, 5'h05, 5'h1F};
  int          err_count = 0, checks = 0, cyc = 0, n;
  adcts_top i_dut (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rc_tick, .sample_start, .scan_slot, .conv_clock_source_sel,
    .tad_tick, .sampling, .sample_done, .ch1_src, .ch2_src, .ch3_src, .an_repurposed,
    .slot_scanned, .slot_src);
  adcts_conv_model i_model (.clk_sys, .srst, .clr, .tad_tick, .sampling, .rc_tick, .ticks);
  always #5 clk_sys = ~clk_sys;
  task automatic end_of_test;
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // a hang anywhere ends here rather than spinning forever
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, r, exp);
  endtask : rd
  // first interval after a write may still run on the old setting
  task automatic period(output int k);
    k = 0;
    do @(posedge clk_sys); while (tad_tick !== 1'b1);
    do begin @(posedge clk_sys); k++; end while (tad_tick !== 1'b1 && k < 400);
  endtask : period
  function automatic logic [14:0] steer(input logic c, input logic [2:0] oa);
    if (c) return {oa[0] ? ADCTS_SRC_OA1 : ADCTS_SRC_AN3, oa[1] ? ADCTS_SRC_OA2 : ADCTS_SRC_AN0,
                   oa[2] ? ADCTS_SRC_OA3 : ADCTS_SRC_AN6};
    return {oa[1] ? ADCTS_SRC_OA2 : ADCTS_SRC_AN0, ADCTS_SRC_AN1, ADCTS_SRC_AN2};
  endfunction : steer
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(ADCTS_OFF_TIMING, 32'h0, "tim_rst");
    chk("slverr_ok", slv, 32'h0);
    rd(ADCTS_OFF_SCAN, 32'h0, "scan_rst");
    rd(12'h014, 32'h0, "unmapped");
    chk("slverr", slv, 32'h1);
    wr(ADCTS_OFF_TIMING, 32'hFFFFFFFF, 4'h3);
    rd(ADCTS_OFF_TIMING, 32'h9FFF, "tim_mask");
    chk("src_out", conv_clock_source_sel, 32'h1);
    wr(ADCTS_OFF_TIMING, 32'h0, 4'h1);
    rd(ADCTS_OFF_TIMING, 32'h9F00, "tim_lane");
    foreach (dv[i]) begin
      wr(ADCTS_OFF_TIMING, {24'h0, dv[i]}, 4'h3);
      period(n);
      period(n);
      chk("tad_div", n, {24'h0, dv[i]} + 32'h1);
    end
    wr(ADCTS_OFF_TIMING, 32'h8005, 4'h3);
    rd(ADCTS_OFF_STATUS, 32'h1, "status_rc");
    period(n);
    period(n);
    chk("rc_period", n, 32'h4);
    foreach (sv[i]) begin
      wr(ADCTS_OFF_TIMING, {16'h0, 3'h4, sv[i], 8'h05}, 4'h3);
      clr <= 1'b1;
      sample_start <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      sample_start <= 1'b0;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (sample_done !== 1'b1 && n < 300);
      if (sv[i] == 5'h00) chk("samc0", n, 32'h2);
      else chk("auto_sample_periods", {24'h0, ticks}, {27'h0, sv[i]});
    end
    for (int k = 0; k < 16; k++) begin
      wr(ADCTS_OFF_MODE, {28'h0, k[2:0], 1'b0}, 4'h3);
      wr(ADCTS_OFF_CHSEL, {31'h0, k[3]}, 4'h3);
      repeat (3) @(posedge clk_sys);
      chk("steer", {ch1_src, ch2_src, ch3_src}, steer(k[3], k[2:0]));
      chk("repurp", an_repurposed != 8'h00, k[2:0] != 3'h0);
    end
    wr(ADCTS_OFF_MODE, 32'hF0, 4'h3);
    rd(ADCTS_OFF_MODE, 32'h70, "mode_rsvd");
    chk("repurp_cmp", an_repurposed != 8'h00, 32'h1);
    wr(ADCTS_OFF_MODE, 32'h1, 4'h3);
    wr(ADCTS_OFF_CHSEL, 32'h1, 4'h3);
    rd(ADCTS_OFF_CHSEL, 32'h0, "chsel_12b");
    wr(ADCTS_OFF_MODE, 32'h0, 4'h3);
    rd(ADCTS_OFF_CHSEL, 32'h0, "chsel_drop");
    wr(ADCTS_OFF_SCAN, 32'hA5C3, 4'h3);
    rd(ADCTS_OFF_SCAN, 32'hA5C3, "scan_rw");
    for (int s = 0; s < 16; s++) begin
      scan_slot <= s[3:0];
      repeat (3) @(posedge clk_sys);
      chk("scanned", slot_scanned, (32'hA5C3 >> s) & 32'h1);
      chk("slot_src", slot_src, s < ADCTS_NUM_AN ? s : ADCTS_SRC_NEGATIVE_REFERENCE_LEVEL);
    end
    end_of_test();
  end
endmodule : adcts_top_bench
